/* design/dac_cal_path.sv */
`timescale 1ns/1ps
`default_nettype none

module dac_cal_path (
  input  wire logic         clock_i,
  input  wire logic         srst_i,
  input  wire logic [11:0]  address_i,
  input  wire logic         read_i,
  input  wire logic         write_i,
  input  wire logic [31:0]  writedata_i,
  output var  logic [31:0]  readdata_o,
  output var  logic         waitrequest_o,
  input  wire logic         load_outputs_n_i,
  input  wire logic         clear_n_i,
  output var  logic         busy_n_o,
  output var  logic         output_ground_o,
  output var  logic         power_down_o,
  output var  logic         thermal_enable_o,
  output var  logic [559:0] dac_code_o,
  output var  logic [41:0]  offset_dac_code_o
);

  localparam int NCH = dac_cal_pkg::NUM_CH;
  localparam int CW  = dac_cal_pkg::CODE_W;

  // ---------------------------------------------------------------
  // Registers and state.
  // ---------------------------------------------------------------
  logic [2:0]              ctrl;
  logic [NCH-1:0]          src_sel;
  logic [CW-1:0]           cal_a [NCH];
  logic [CW-1:0]           cal_b [NCH];
  logic [NCH-1:0]          dirty_a;
  logic [NCH-1:0]          dirty_b;
  logic                    ack;
  logic                    rd_stage;
  dac_cal_pkg::eng_state_t eng_state;
  logic [5:0]              eng_ch;
  logic                    eng_bank;
  logic [2:0]              sel_cnt;
  logic [11:0]             init_cnt;
  logic                    init_done;
  logic                    ld_s1;
  logic                    ld_s2;
  logic                    ld_s3;
  logic                    clr_s1;
  logic                    clr_s2;
  logic                    load_pend;

  // ---------------------------------------------------------------
  // Decode and combinational helpers.
  // ---------------------------------------------------------------
  logic [5:0]    ch_idx;
  logic          ch_ok;
  logic          win_data;
  logic          win_gain;
  logic          win_trim;
  logic          wr_fire;
  logic          start;
  logic          bank;
  logic          busy_int;
  logic          load_fire;
  logic          ld_fall;
  logic [5:0]    mem_raddr;
  logic [CW-1:0] rd_a;
  logic [CW-1:0] rd_b;
  logic [CW-1:0] rd_gain;
  logic [CW-1:0] rd_trim;
  logic [CW-1:0] calc_out;
  logic [31:0]   bus_rdata;

  assign bank = ctrl[dac_cal_pkg::CTRL_BANK_BIT];

  // Per-channel windows: 0x100 data, 0x200 gain, 0x300 trim.
  always_comb
  begin
    ch_idx   = address_i[7:2];
    ch_ok    = (ch_idx < NCH);
    win_data = (address_i[11:8] == dac_cal_pkg::WIN_DATA) && ch_ok;
    win_gain = (address_i[11:8] == dac_cal_pkg::WIN_GAIN) && ch_ok;
    win_trim = (address_i[11:8] == dac_cal_pkg::WIN_TRIM) && ch_ok;
  end

  // A write takes effect at the edge where waitrequest is seen low.
  assign wr_fire = write_i && ack;
  assign start   = wr_fire && (win_data || win_gain || win_trim);

  // Internal busy covers calculation and the select-write hold-off.
  assign busy_int = start || (eng_state != dac_cal_pkg::ENG_IDLE)
                    || (sel_cnt != 3'h0);

  // The memories follow the engine while it runs, else the bus.
  assign mem_raddr = (eng_state != dac_cal_pkg::ENG_IDLE) ? eng_ch : ch_idx;

  // ---------------------------------------------------------------
  // Per-channel stores.
  // ---------------------------------------------------------------
  word_memory #(
    .DEPTH       (NCH),
    .WIDTH       (CW),
    .AW          (6),
    .RESET_VALUE (dac_cal_pkg::INPUT_RESET)
  ) u_input_a (
    .clock_i      (clock_i),
    .srst_i       (srst_i),
    .write_en_i   (wr_fire && win_data && !bank),
    .write_addr_i (ch_idx),
    .write_data_i (writedata_i[CW-1:0]),
    .read_addr_i  (mem_raddr),
    .read_data_o  (rd_a)
  );

  word_memory #(
    .DEPTH       (NCH),
    .WIDTH       (CW),
    .AW          (6),
    .RESET_VALUE (dac_cal_pkg::INPUT_RESET)
  ) u_input_b (
    .clock_i      (clock_i),
    .srst_i       (srst_i),
    .write_en_i   (wr_fire && win_data && bank),
    .write_addr_i (ch_idx),
    .write_data_i (writedata_i[CW-1:0]),
    .read_addr_i  (mem_raddr),
    .read_data_o  (rd_b)
  );

  word_memory #(
    .DEPTH       (NCH),
    .WIDTH       (CW),
    .AW          (6),
    .RESET_VALUE (dac_cal_pkg::GAIN_RESET)
  ) u_gain (
    .clock_i      (clock_i),
    .srst_i       (srst_i),
    .write_en_i   (wr_fire && win_gain),
    .write_addr_i (ch_idx),
    .write_data_i (writedata_i[CW-1:0]),
    .read_addr_i  (mem_raddr),
    .read_data_o  (rd_gain)
  );

  word_memory #(
    .DEPTH       (NCH),
    .WIDTH       (CW),
    .AW          (6),
    .RESET_VALUE (dac_cal_pkg::TRIM_RESET)
  ) u_trim (
    .clock_i      (clock_i),
    .srst_i       (srst_i),
    .write_en_i   (wr_fire && win_trim),
    .write_addr_i (ch_idx),
    .write_data_i (writedata_i[CW-1:0]),
    .read_addr_i  (mem_raddr),
    .read_data_o  (rd_trim)
  );

  // One arithmetic unit for all forty channels.
  gain_offset_calc u_calc (
    .clock_i   (clock_i),
    .srst_i    (srst_i),
    .in_code_i (eng_bank ? rd_b : rd_a),
    .gain_i    (rd_gain),
    .trim_i    (rd_trim),
    .code_o    (calc_out)
  );

  // ---------------------------------------------------------------
  // Calculation engine.
  // ---------------------------------------------------------------
  // The bank is latched at start so a later control write cannot
  // redirect a result that is already in flight.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      eng_state <= dac_cal_pkg::ENG_IDLE;
      eng_ch    <= 6'h00;
      eng_bank  <= 1'b0;
    end
    else
    begin
      case (eng_state)
        dac_cal_pkg::ENG_IDLE:
        begin
          if (start)
          begin
            eng_ch    <= ch_idx;
            eng_bank  <= bank;
            eng_state <= dac_cal_pkg::ENG_READ;
          end
        end
        dac_cal_pkg::ENG_READ:  eng_state <= dac_cal_pkg::ENG_CALC;
        dac_cal_pkg::ENG_CALC:  eng_state <= dac_cal_pkg::ENG_STORE;
        dac_cal_pkg::ENG_STORE: eng_state <= dac_cal_pkg::ENG_IDLE;
        default:                eng_state <= dac_cal_pkg::ENG_IDLE;
      endcase
    end
  end

  // Calibrated words are internal only; no bus path reaches them.
  // Their reset value equals the result of the default calculation.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        cal_a[i] <= dac_cal_pkg::INPUT_RESET;
        cal_b[i] <= dac_cal_pkg::INPUT_RESET;
      end
    end
    else if (eng_state == dac_cal_pkg::ENG_STORE)
    begin
      if (eng_bank)
        cal_b[eng_ch] <= calc_out;
      else
        cal_a[eng_ch] <= calc_out;
    end
  end

  // Change tracking: a new result sets its flag after the clear.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      dirty_a <= '0;
      dirty_b <= '0;
    end
    else
    begin
      if (load_fire)
      begin
        dirty_a <= '0;
        dirty_b <= '0;
      end
      if (eng_state == dac_cal_pkg::ENG_STORE)
      begin
        if (eng_bank)
          dirty_b[eng_ch] <= 1'b1;
        else
          dirty_a[eng_ch] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers.
  // ---------------------------------------------------------------
  // The strobe line idles high, so the chain resets high.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      ld_s1  <= 1'b1;
      ld_s2  <= 1'b1;
      ld_s3  <= 1'b1;
      clr_s1 <= 1'b0;
      clr_s2 <= 1'b0;
    end
    else
    begin
      ld_s1  <= load_outputs_n_i;
      ld_s2  <= ld_s1;
      ld_s3  <= ld_s2;
      clr_s1 <= clear_n_i;
      clr_s2 <= clr_s1;
    end
  end

  assign ld_fall = ld_s3 && !ld_s2;

  // ---------------------------------------------------------------
  // Load strobe handling.
  // ---------------------------------------------------------------
  // A held-low strobe reloads whenever fresh results exist.
  assign load_fire = !busy_int && clr_s2 && (load_pend
                     || (!ld_s2 && ((dirty_a | dirty_b) != '0)));

  // Strobes while clear is low are dropped; a new fall beats the clear.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      load_pend <= 1'b0;
    else
      load_pend <= (load_pend && !load_fire) || (ld_fall && clr_s2);
  end

  // All channels load in one edge, each only if its word changed.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      for (int i = 0; i < NCH; i++)
        dac_code_o[i*CW +: CW] <= dac_cal_pkg::INPUT_RESET;
    end
    else if (load_fire)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (src_sel[i] ? dirty_b[i] : dirty_a[i])
          dac_code_o[i*CW +: CW] <= src_sel[i] ? cal_b[i] : cal_a[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Busy, init and output grounding.
  // ---------------------------------------------------------------
  // Select writes hold busy so a load cannot race the new mux setting.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      sel_cnt <= 3'h0;
    else if (wr_fire && ((address_i == dac_cal_pkg::ADDR_SEL_ALL)
             || ((address_i >= dac_cal_pkg::ADDR_SEL_BASE)
             && (address_i < dac_cal_pkg::ADDR_OFS_BASE))))
      sel_cnt <= 3'(dac_cal_pkg::SEL_BUSY_CYC);
    else if (sel_cnt != 3'h0)
      sel_cnt <= sel_cnt - 3'h1;
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      busy_n_o <= 1'b1;
    else
      busy_n_o <= !(start || ((eng_state != dac_cal_pkg::ENG_IDLE)
                  && (eng_state != dac_cal_pkg::ENG_STORE))
                  || (sel_cnt > 3'h1));
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      init_cnt  <= 12'h000;
      init_done <= 1'b0;
    end
    else if (!init_done)
    begin
      init_cnt  <= init_cnt + 12'h001;
      init_done <= (init_cnt == 12'(dac_cal_pkg::INIT_CYC - 1));
    end
  end

  // Power-down also parks the outputs at the ground reference.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      output_ground_o <= 1'b1;
    else
      output_ground_o <= !init_done || !clr_s2
                         || ctrl[dac_cal_pkg::CTRL_PD_BIT];
  end

  // ---------------------------------------------------------------
  // Register bus writes.
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      ctrl              <= dac_cal_pkg::CTRL_RESET;
      src_sel           <= {dac_cal_pkg::NUM_GRP{dac_cal_pkg::SEL_RESET}};
      offset_dac_code_o <= {dac_cal_pkg::NUM_OFS{dac_cal_pkg::OFS_RESET}};
    end
    else if (wr_fire)
    begin
      if (address_i == dac_cal_pkg::ADDR_CTRL)
        ctrl <= writedata_i[2:0];
      else if (address_i == dac_cal_pkg::ADDR_SEL_ALL)
        src_sel <= {NCH{writedata_i[0]}};
      for (int g = 0; g < dac_cal_pkg::NUM_GRP; g++)
      begin
        if (address_i == dac_cal_pkg::ADDR_SEL_BASE + 12'(4 * g))
          src_sel[g*8 +: 8] <= writedata_i[7:0];
      end
      for (int k = 0; k < dac_cal_pkg::NUM_OFS; k++)
      begin
        if (address_i == dac_cal_pkg::ADDR_OFS_BASE + 12'(4 * k))
          offset_dac_code_o[k*CW +: CW] <= writedata_i[CW-1:0];
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      power_down_o     <= 1'b0;
      thermal_enable_o <= 1'b0;
    end
    else
    begin
      power_down_o     <= ctrl[dac_cal_pkg::CTRL_PD_BIT];
      thermal_enable_o <= ctrl[dac_cal_pkg::CTRL_TSD_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Register bus reads.
  // ---------------------------------------------------------------
  // Unmapped addresses, including calibrated and final words, read 0.
  always_comb
  begin
    bus_rdata = 32'h0000_0000;
    if (address_i == dac_cal_pkg::ADDR_CTRL)
      bus_rdata = {29'h0, ctrl};
    else if (address_i == dac_cal_pkg::ADDR_STATUS)
      bus_rdata = {27'h0, output_ground_o, clr_s2, init_done,
                   load_pend, busy_int};
    else if (win_data)
      bus_rdata = {18'h0, bank ? rd_b : rd_a};
    else if (win_gain)
      bus_rdata = {18'h0, rd_gain};
    else if (win_trim)
      bus_rdata = {18'h0, rd_trim};
    for (int g = 0; g < dac_cal_pkg::NUM_GRP; g++)
    begin
      if (address_i == dac_cal_pkg::ADDR_SEL_BASE + 12'(4 * g))
        bus_rdata = {24'h0, src_sel[g*8 +: 8]};
    end
    for (int k = 0; k < dac_cal_pkg::NUM_OFS; k++)
    begin
      if (address_i == dac_cal_pkg::ADDR_OFS_BASE + 12'(4 * k))
        bus_rdata = {18'h0, offset_dac_code_o[k*CW +: CW]};
    end
  end

  // ---------------------------------------------------------------
  // Handshake.
  // ---------------------------------------------------------------
  // Reads take one extra cycle for the memory read register. Writes
  // wait for an idle engine, which stretches waitrequest while the engine runs but not during the select hold-off.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      ack        <= 1'b0;
      rd_stage   <= 1'b0;
      readdata_o <= 32'h0000_0000;
    end
    else if (ack)
      ack <= 1'b0;
    else if (rd_stage)
    begin
      rd_stage   <= 1'b0;
      ack        <= 1'b1;
      readdata_o <= bus_rdata;
    end
    else if (read_i && (eng_state == dac_cal_pkg::ENG_IDLE))
      rd_stage <= 1'b1;
    else if (write_i && (eng_state == dac_cal_pkg::ENG_IDLE))
      ack <= 1'b1;
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      waitrequest_o <= 1'b1;
    else
      waitrequest_o <= !(!ack && (rd_stage || (write_i && !read_i
                       && !rd_stage && eng_state == dac_cal_pkg::ENG_IDLE)));
  end

endmodule // dac_cal_path

`default_nettype wire

/* design/dac_cal_pkg.sv */
package dac_cal_pkg;

  // ---------------------------------------------------------------
  // Geometry of the channel array.
  // ---------------------------------------------------------------
  localparam int NUM_CH    = 40;
  localparam int CODE_W    = 14;
  localparam int CH_W      = 6;
  localparam int NUM_GRP   = 5;
  localparam int GRP_SIZE  = 8;
  localparam int NUM_OFS   = 3;
  localparam int GAIN_SHIFT = 14;

  // ---------------------------------------------------------------
  // Values after reset, and the code limits used by the calculation.
  // ---------------------------------------------------------------
  localparam logic [13:0] INPUT_RESET = 14'h1555;
  localparam logic [13:0] GAIN_RESET  = 14'h3FFF;
  localparam logic [13:0] TRIM_RESET  = 14'h2000;
  localparam logic [13:0] OFS_RESET   = 14'h1555;
  localparam logic [13:0] CODE_MAX    = 14'h3FFF;
  localparam logic signed [16:0] MID_SCALE = 17'sh02000;
  localparam logic [2:0]  CTRL_RESET  = 3'h0;
  localparam logic [7:0]  SEL_RESET   = 8'h00;

  // ---------------------------------------------------------------
  // Control bit positions.
  // ---------------------------------------------------------------
  localparam int CTRL_PD_BIT   = 0;
  localparam int CTRL_TSD_BIT  = 1;
  localparam int CTRL_BANK_BIT = 2;

  // ---------------------------------------------------------------
  // Byte addresses and window numbers (address bits 11:8) on the register bus.
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_SEL_ALL  = 12'h004;
  localparam logic [11:0] ADDR_STATUS   = 12'h008;
  localparam logic [11:0] ADDR_SEL_BASE = 12'h010;
  localparam logic [11:0] ADDR_OFS_BASE = 12'h030;
  localparam logic [3:0]  WIN_DATA      = 4'h1;
  localparam logic [3:0]  WIN_GAIN      = 4'h2;
  localparam logic [3:0]  WIN_TRIM      = 4'h3;

  // ---------------------------------------------------------------
  // Timing.
  // ---------------------------------------------------------------
  localparam int CLK_MHZ      = 10;
  localparam int SEL_BUSY_NS  = 500;
  localparam int SEL_BUSY_CYC = (SEL_BUSY_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_US      = 300;
  localparam int INIT_CYC     = INIT_US * CLK_MHZ;

  typedef enum logic [1:0] {
    ENG_IDLE  = 2'b00,
    ENG_READ  = 2'b01,
    ENG_CALC  = 2'b11,
    ENG_STORE = 2'b10
  } eng_state_t;

endpackage

/* design/word_memory.sv */
`timescale 1ns/1ps
`default_nettype none

// Small word store with one write port and a registered read port.
module word_memory #(
  parameter int               DEPTH       = 40,
  parameter int               WIDTH       = 14,
  parameter int               AW          = 6,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clock_i,
  input  wire logic             srst_i,
  input  wire logic             write_en_i,
  input  wire logic [AW-1:0]    write_addr_i,
  input  wire logic [WIDTH-1:0] write_data_i,
  input  wire logic [AW-1:0]    read_addr_i,
  output var  logic [WIDTH-1:0] read_data_o
);

  logic [WIDTH-1:0] words [DEPTH];

  // Every word takes its default on reset, so no init walk is needed.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        words[i] <= RESET_VALUE;
    end
    else if (write_en_i && (write_addr_i < DEPTH))
      words[write_addr_i] <= write_data_i;
  end

  // Out-of-range reads return the default rather than unknowns.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      read_data_o <= RESET_VALUE;
    else if (read_addr_i < DEPTH)
      read_data_o <= words[read_addr_i];
    else
      read_data_o <= RESET_VALUE;
  end

endmodule // word_memory

`default_nettype wire

/* design/gain_offset_calc.sv */
`timescale 1ns/1ps
`default_nettype none

// Shared multiply-add stage: one result per clock, one cycle latency.
module gain_offset_calc (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic [13:0] in_code_i,
  input  wire logic [13:0] gain_i,
  input  wire logic [13:0] trim_i,
  output var  logic [13:0] code_o
);

  logic [28:0]        product;
  logic signed [16:0] sum;

  // Scale by gain plus one, drop the fraction, then shift by the trim.
  always_comb
  begin
    product = in_code_i * ({1'b0, gain_i} + 15'h0001);
    sum = $signed({2'h0, product[28:14]}) + $signed({3'h0, trim_i})
          - dac_cal_pkg::MID_SCALE;
  end

  // Clamp so a wild trim never wraps around the code range.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      code_o <= dac_cal_pkg::INPUT_RESET;
    else if (sum < 0)
      code_o <= 14'h0000;
    else if (sum > $signed({3'h0, dac_cal_pkg::CODE_MAX}))
      code_o <= dac_cal_pkg::CODE_MAX;
    else
      code_o <= sum[13:0];
  end

endmodule // gain_offset_calc

`default_nettype wire

/* tb/dac_cal_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------
// Port checks of the calibration path.
// ---------------------------------------
module dac_cal_checker (
  input wire logic         clock_i,
  input wire logic         srst_i,
  input wire logic [11:0]  address_i,
  input wire logic         read_i,
  input wire logic         write_i,
  input wire logic [31:0]  writedata_i,
  input wire logic [31:0]  readdata_o,
  input wire logic         waitrequest_o,
  input wire logic         load_outputs_n_i,
  input wire logic         clear_n_i,
  input wire logic         busy_n_o,
  input wire logic         output_ground_o,
  input wire logic         power_down_o,
  input wire logic         thermal_enable_o,
  input wire logic [559:0] dac_code_o,
  input wire logic [41:0]  offset_dac_code_o
);
  int unsigned since_rst;
  // Cycles since reset; it saturates so the check never wraps.
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      since_rst <= 0;
    else if (since_rst < 4000)
      since_rst <= since_rst + 1;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  ofs_reset_a: assert property ($fell(srst_i) |-> offset_dac_code_o ==
    {3{dac_cal_pkg::OFS_RESET}}) else $error("offset code not at default");
  init_ground_a: assert property ((since_rst < 2990) |-> output_ground_o)
    else $error("output left ground during init");
  clear_ground_a: assert property (!clear_n_i [*4] |=> output_ground_o)
    else $error("clear low but output not grounded");
  busy_freeze_a: assert property (!busy_n_o && $past(!busy_n_o) |->
    $stable(dac_code_o)) else $error("final code moved while busy");
  ctrl_copy_a: assert property (write_i && !waitrequest_o && address_i ==
    dac_cal_pkg::ADDR_CTRL |-> ##2 power_down_o == $past(writedata_i[0], 2)
    && thermal_enable_o == $past(writedata_i[1], 2))
    else $error("control copy wrong");
  pd_ground_a: assert property (power_down_o && $past(power_down_o) |->
    output_ground_o) else $error("power-down not grounded");
  no_access_a: assert property (read_i && !waitrequest_o &&
    address_i >= 12'h400 |-> readdata_o == 32'h0)
    else $error("unmapped read not zero");
  ack_once_a: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("waitrequest low twice");
  busy_low_a: assert property (write_i && !waitrequest_o &&
    address_i[11:8] inside {4'h1, 4'h2, 4'h3} && address_i[7:2] < 6'h28
    |=> !busy_n_o [*3]) else $error("busy not low during calculation");
  cover property (!load_outputs_n_i && !busy_n_o);
  cover property ($fell(output_ground_o));
  cover property (write_i && !waitrequest_o &&
    address_i == dac_cal_pkg::ADDR_SEL_ALL);
endmodule // dac_cal_checker

bind dac_cal_path dac_cal_checker u_chk (.clock_i, .srst_i, .address_i,
  .read_i, .write_i, .writedata_i, .readdata_o, .waitrequest_o,
  .load_outputs_n_i, .clear_n_i, .busy_n_o, .output_ground_o,
  .power_down_o, .thermal_enable_o, .dac_code_o, .offset_dac_code_o);
`default_nettype wire

/* tb/avalon_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------
// Host side of the register bus.
// ---------------------------------------
module avalon_host (
  input  wire logic        clock_i,
  input  wire logic        waitrequest_i,
  input  wire logic [31:0] readdata_i,
  output var  logic [11:0] address_o,
  output var  logic        read_o,
  output var  logic        write_o,
  output var  logic [31:0] writedata_o
);
  // Bus idles at time zero so no request precedes reset release.
  initial
  begin
    address_o = 12'h000;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0;
  end
  // Request held until waitrequest is sampled low; a spare cycle follows
  // so a strobe is never lowered and raised in one time step.
  task automatic bus_write(input logic [11:0] a, input logic [31:0] d);
    address_o <= a;
    writedata_o <= d;
    write_o <= 1'b1;
    @(posedge clock_i);
    while (waitrequest_i) @(posedge clock_i);
    write_o <= 1'b0;
    @(posedge clock_i);
  endtask
  // Data is taken at the very edge that ends the wait.
  task automatic bus_read(input logic [11:0] a, output logic [31:0] d);
    address_o <= a;
    read_o <= 1'b1;
    @(posedge clock_i);
    while (waitrequest_i) @(posedge clock_i);
    d = readdata_i;
    read_o <= 1'b0;
    @(posedge clock_i);
  endtask
endmodule // avalon_host
`default_nettype wire

/* tb/multichannel_dac_calibration_path_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------
// Self-checking bench.
// ---------------------------------------
module multichannel_dac_calibration_path_tb;
  typedef struct packed {logic [5:0] ch; logic [13:0] g, t, x, e;} row_t;
  logic         clock_i = 1'b0;
  logic         srst_i = 1'b1;
  logic         load_n = 1'b1;
  logic         clear_n = 1'b0;
  logic         wreq, rd_s, wr_s, busy_n, gnd, pd, te;
  logic [11:0]  addr;
  logic [31:0]  wdat, rdat, got;
  logic [559:0] code;
  logic [41:0]  ofs;
  int           miscompares = 0;
  int           samples_checked = 0;
  // Channel, gain, trim, input word, expected final code.
  row_t rows [5] = '{'{6'd0, 14'h3FFF, 14'h2000, 14'h0100, 14'h0100},
    '{6'd9, 14'h1FFF, 14'h2000, 14'h1000, 14'h0800},
    '{6'd39, 14'h3FFF, 14'h0000, 14'h0100, 14'h0000},
    '{6'd20, 14'h3FFF, 14'h3FFF, 14'h3000, 14'h3FFF},
    '{6'd5, 14'h3FBB, 14'h2029, 14'h1000, 14'h1018}};
  dac_cal_path u_dut (.clock_i, .srst_i, .address_i(addr), .read_i(rd_s),
    .write_i(wr_s), .writedata_i(wdat), .readdata_o(rdat),
    .waitrequest_o(wreq), .load_outputs_n_i(load_n), .clear_n_i(clear_n),
    .busy_n_o(busy_n), .output_ground_o(gnd), .power_down_o(pd),
    .thermal_enable_o(te), .dac_code_o(code), .offset_dac_code_o(ofs));
  avalon_host u_host (.clock_i, .waitrequest_i(wreq), .readdata_i(rdat),
    .address_o(addr), .read_o(rd_s), .write_o(wr_s), .writedata_o(wdat));
  // Free-running 10 MHz clock.
  initial
  begin
    forever #50 clock_i = ~clock_i;
  end
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    u_host.bus_read(a, got);
    cmp_word(got, e);
  endtask
  task automatic pulse();
    load_n <= 1'b0;
    repeat (4) @(posedge clock_i);
    load_n <= 1'b1;
  endtask
  // Waits a bounded time for the loaded code, then compares it.
  task automatic see(input int ch, input logic [13:0] e);
    int n = 0;
    while (code[ch*14 +: 14] !== e && n < 40)
    begin
      @(posedge clock_i);
      n++;
    end
    cmp_word(32'(code[ch*14 +: 14]), 32'(e));
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // The run needs just over 3000 cycles; over six times that means a hang.
  initial
  begin
    repeat (20000) @(posedge clock_i);
    miscompares++;
    wrap_up();
  end
  initial
  begin
    repeat (8) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    cmp_word(32'(gnd), 32'h1);
    for (int k = 0; k < 3; k++) cmp_word(32'(ofs[k*14 +: 14]), 32'h1555);
    rd(12'h000, 32'h0);
    rd(12'h100, 32'h1555);
    rd(12'h200, 32'h3FFF);
    rd(12'h300, 32'h2000);
    repeat (dac_cal_pkg::INIT_CYC + 8) @(posedge clock_i);
    cmp_word(32'(gnd), 32'h1);
    clear_n <= 1'b1;
    repeat (8) @(posedge clock_i);
    cmp_word(32'(gnd), 32'h0);
    foreach (rows[i])
    begin
      u_host.bus_write(12'h200 + {rows[i].ch, 2'b00}, 32'(rows[i].g));
      u_host.bus_write(12'h300 + {rows[i].ch, 2'b00}, 32'(rows[i].t));
      u_host.bus_write(12'h100 + {rows[i].ch, 2'b00}, 32'(rows[i].x));
      pulse();
      see(rows[i].ch, rows[i].e);
    end
    // Bank B write, then the per-channel select picks it up.
    u_host.bus_write(12'h000, 32'h4);
    u_host.bus_write(12'h104, 32'h200);
    rd(12'h104, 32'h200);
    u_host.bus_write(12'h000, 32'h0);
    rd(12'h104, 32'h1555);
    u_host.bus_write(12'h010, 32'h3);
    pulse();
    see(1, 14'h0200);
    cmp_word(32'(code[13:0]), 32'h0100);
    u_host.bus_write(12'h004, 32'h1);
    for (int g = 0; g < 5; g++) rd(12'h010 + 12'(4*g), 32'hFF);
    u_host.bus_write(12'h004, 32'h0);
    rd(12'h020, 32'h0);
    // Strobe held low: each new result reaches the output by itself.
    load_n <= 1'b0;
    u_host.bus_write(12'h108, 32'h300);
    see(2, 14'h0300);
    u_host.bus_write(12'h10C, 32'h123);
    see(3, 14'h0123);
    load_n <= 1'b1;
    u_host.bus_write(12'h000, 32'h3);
    repeat (4) @(posedge clock_i);
    cmp_word(32'({pd, te, gnd}), 32'h7);
    u_host.bus_write(12'h000, 32'h0);
    u_host.bus_write(12'h038, 32'h2000);
    repeat (3) @(posedge clock_i);
    cmp_word(32'(ofs[41:28]), 32'h2000);
    // A short strobe inside the select hold-off must be remembered.
    u_host.bus_write(12'h110, 32'h00AB);
    u_host.bus_write(12'h004, 32'h0);
    load_n <= 1'b0;
    @(posedge clock_i);
    load_n <= 1'b1;
    see(4, 14'h00AB);
    rd(12'h7FC, 32'h0);
    // A second reset in mid-run restores the defaults.
    srst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    cmp_word(32'(code[69:56]), 32'h1555);
    cmp_word(32'(ofs[41:28]), 32'h1555);
    rd(12'h108, 32'h1555);
    wrap_up();
  end
endmodule // multichannel_dac_calibration_path_tb
`default_nettype wire
